// ==== gpsi_pkg.sv ====
`default_nettype none
package gpsi_pkg;
  localparam int          ADDR_W         = 10;
  localparam int          DATA_W         = 32;
  localparam int          NUM_PORTS      = 2;
  localparam int          MODE_W         = 2;
  localparam int          RST_W          = 2;
  localparam int          TERM_W         = 4;
  // Pad words: pad index in addr[7:3], word select in addr[2].
  localparam logic [1:0]  REGION_PAD     = 2'h0;
  localparam logic [1:0]  REGION_SPI     = 2'h1;
  localparam logic [1:0]  REGION_MISC    = 2'h2;
  localparam int          PAD_IDX_LSB    = 3;
  localparam int          PAD_IDX_W      = 5;
  localparam int          PAD_WORD_BIT   = 2;
  localparam int          SPI_PORT_BIT   = 4;
  localparam logic [1:0]  SPI_CTRL_OFS   = 2'h0;
  localparam logic [1:0]  SPI_DATA_OFS   = 2'h1;
  localparam logic [1:0]  SPI_STAT_OFS   = 2'h2;
  localparam logic [ADDR_W-1:0] OWN_ADDR   = 10'h200;
  localparam logic [ADDR_W-1:0] STRAP_ADDR = 10'h204;
  localparam logic [ADDR_W-1:0] PLT_ADDR   = 10'h208;
  // First configuration word fields.
  localparam int          DW0_TXVAL_BIT  = 0;
  localparam int          DW0_RXVAL_BIT  = 1;
  localparam int          DW0_TXDIS_BIT  = 8;
  localparam int          DW0_RXDIS_BIT  = 9;
  localparam int          DW0_MODE_LSB   = 10;
  localparam int          DW0_RST_LSB    = 30;
  localparam logic [31:0] DW0_WMASK      = 32'hc000_0f01;
  localparam logic [31:0] DW0_DEF_GPIO   = 32'h0000_0300;
  localparam logic [31:0] DW0_DEF_NATIVE = 32'h0000_0400;
  // Second configuration word fields.
  localparam int          DW1_TERM_LSB   = 10;
  localparam int          DW1_VTOL_BIT   = 25;
  localparam logic [31:0] DW1_WMASK      = 32'h0200_3c00;
  localparam logic [31:0] DW1_DEF        = 32'h0000_0000;
  localparam int          TERM_UP_BIT    = 3;
  localparam logic [RST_W-1:0]  RST_SRC_PLT = 2'h2;
  localparam logic [MODE_W-1:0] MODE_GPIO   = 2'h0;
  // Serial port control fields.
  localparam int          SPI_GO_BIT     = 0;
  localparam int          SPI_DIV_LSB    = 8;
  localparam int          SPI_DIV_W      = 8;
  localparam int          SPI_BUSY_BIT   = 0;
  localparam logic [7:0]  SPI_DIV_DEF    = 8'h04;
  localparam logic [1:0]  STRAP_WAIT     = 2'h3;
  typedef enum logic [1:0] {GPSI_SP_IDLE, GPSI_SP_SHIFT} gpsi_sp_state_e;
endpackage
`default_nettype wire

// ==== gpsi_pad_cell.sv ====
`timescale 1ns/100ps
`default_nettype none
module gpsi_pad_cell #(
  parameter bit IS_NATIVE = 1'b0,
  parameter bit VTOL_OK   = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        plt_active,
  input  wire logic        engine_owned,
  input  wire logic        wr_en,
  input  wire logic        wr_word,
  input  wire logic [31:0] wr_data,
  input  wire logic        pad_in,
  input  wire logic        native_out,
  input  wire logic        native_oe,
  output logic             pad_out,
  output logic             pad_oe,
  output logic             pull_up,
  output logic             pull_dn,
  output logic             vtol_1v8,
  output logic [1:0]       mode,
  output logic             rx_level,
  output logic [31:0]      dw0,
  output logic [31:0]      dw1
);
  localparam logic [31:0] DW0_DEF = IS_NATIVE ? gpsi_pkg::DW0_DEF_NATIVE : gpsi_pkg::DW0_DEF_GPIO;
  // Native-default pads keep the reset select fixed; their controller isolates them.
  localparam logic [31:0] RST_FIX = IS_NATIVE ? 32'h3fff_ffff : 32'hffff_ffff;
  localparam logic [31:0] VT_MSK  = VTOL_OK ? 32'hffff_ffff : 32'hfdff_ffff;
  localparam logic [31:0] W0_MSK  = gpsi_pkg::DW0_WMASK & RST_FIX;
  localparam logic [31:0] W1_MSK  = gpsi_pkg::DW1_WMASK & VT_MSK;

  logic [31:0] dw0_q;
  logic [31:0] dw1_q;
  logic        s1_q, s2_q, s3_q, in_q;
  logic        pad_rst;
  logic        gpio;

  assign pad_rst = plt_active &&
                   dw0_q[gpsi_pkg::DW0_RST_LSB +: gpsi_pkg::RST_W] == gpsi_pkg::RST_SRC_PLT;
  assign mode    = dw0_q[gpsi_pkg::DW0_MODE_LSB +: gpsi_pkg::MODE_W];
  assign gpio    = mode == gpsi_pkg::MODE_GPIO;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dw0_q <= DW0_DEF;
      dw1_q <= gpsi_pkg::DW1_DEF;
    end else if (pad_rst) begin
      // Both words return to defaults, which disables rx/tx and drops native mode.
      dw0_q <= DW0_DEF;
      dw1_q <= gpsi_pkg::DW1_DEF;
    end else if (wr_en && !engine_owned) begin
      if (wr_word)
        dw1_q <= (dw1_q & ~W1_MSK) | (wr_data & W1_MSK);
      else
        dw0_q <= (dw0_q & ~W0_MSK) | (wr_data & W0_MSK);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      in_q <= 1'b0;
    end else begin
      s1_q <= pad_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        in_q <= s3_q;
    end
  end

  assign rx_level = in_q & ~dw0_q[gpsi_pkg::DW0_RXDIS_BIT];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b0;
    end else begin
      pad_out <= gpio ? dw0_q[gpsi_pkg::DW0_TXVAL_BIT] : native_out;
      pad_oe  <= ~dw0_q[gpsi_pkg::DW0_TXDIS_BIT] & (gpio | native_oe);
    end
  end

  assign pull_up  = dw1_q[gpsi_pkg::DW1_TERM_LSB + gpsi_pkg::TERM_UP_BIT];
  assign pull_dn  = !pull_up && dw1_q[gpsi_pkg::DW1_TERM_LSB +: gpsi_pkg::TERM_W] != 4'h0;
  assign vtol_1v8 = dw1_q[gpsi_pkg::DW1_VTOL_BIT];
  assign dw0      = {dw0_q[31:2], rx_level, dw0_q[0]};
  assign dw1      = dw1_q;
endmodule // gpsi_pad_cell
`default_nettype wire

// ==== gpsi_serial_port.sv ====
`timescale 1ns/100ps
`default_nettype none
module gpsi_serial_port #(
  parameter int DATA_W = 8,
  parameter int DIV_W  = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              start,
  input  wire logic [DATA_W-1:0] tx_data,
  input  wire logic [DIV_W-1:0]  div,
  input  wire logic              miso,
  output logic                   busy,
  output logic [DATA_W-1:0]      rx_data,
  output logic                   sclk,
  output logic                   cs_n,
  output logic                   mosi
);
  gpsi_pkg::gpsi_sp_state_e state_q;
  logic [DIV_W-1:0]  cnt_q;
  logic [DATA_W-1:0] sh_q;
  logic [7:0]        bits_q;
  logic              m1_q, m2_q, m3_q, min_q, smp_q;
  logic              tick;

  // Half-bit enable pulse from the divider.
  assign tick = state_q == gpsi_pkg::GPSI_SP_SHIFT && cnt_q == div;
  assign busy = state_q == gpsi_pkg::GPSI_SP_SHIFT;
  assign mosi = sh_q[DATA_W-1];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      m1_q  <= 1'b0;
      m2_q  <= 1'b0;
      m3_q  <= 1'b0;
      min_q <= 1'b0;
    end else begin
      m1_q <= miso;
      m2_q <= m1_q;
      m3_q <= m2_q;
      if (m2_q == m3_q)
        min_q <= m3_q;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= gpsi_pkg::GPSI_SP_IDLE;
      cnt_q   <= '0;
      sh_q    <= '0;
      bits_q  <= 8'h00;
      smp_q   <= 1'b0;
      sclk    <= 1'b0;
      cs_n    <= 1'b1;
      rx_data <= '0;
    end else begin
      case (state_q)
        gpsi_pkg::GPSI_SP_IDLE: begin
          if (start) begin
            state_q <= gpsi_pkg::GPSI_SP_SHIFT;
            sh_q    <= tx_data;
            bits_q  <= 8'(DATA_W);
            cnt_q   <= '0;
            cs_n    <= 1'b0;
          end
        end
        gpsi_pkg::GPSI_SP_SHIFT: begin
          cnt_q <= tick ? '0 : cnt_q + 1'b1;
          if (tick) begin
            sclk <= ~sclk;
            if (!sclk) begin
              smp_q <= min_q;
            end else begin
              sh_q   <= {sh_q[DATA_W-2:0], smp_q};
              bits_q <= bits_q - 8'h01;
              if (bits_q == 8'h01) begin
                state_q <= gpsi_pkg::GPSI_SP_IDLE;
                rx_data <= {sh_q[DATA_W-2:0], smp_q};
                cs_n    <= 1'b1;
              end
            end
          end
        end
        default: state_q <= gpsi_pkg::GPSI_SP_IDLE;
      endcase
    end
  end
endmodule // gpsi_serial_port
`default_nettype wire

// ==== gpsi_top.sv ====
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module gpsi_top #(
  parameter int              NUM_PADS     = 8,
  parameter logic [31:0]     NATIVE_DEF   = 32'h0000_0080,
  parameter logic [31:0]     VTOL_CAPABLE = 32'h0000_0003,
  parameter int              SPI_DATA_W   = 8
) (
  input  wire logic [9:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  platform_reset_n,
  input  wire logic                  engine_own_wr,
  input  wire logic [NUM_PADS-1:0]   engine_own_data,
  input  wire logic [NUM_PADS-1:0]   pad_in,
  output logic      [NUM_PADS-1:0]   pad_out,
  output logic      [NUM_PADS-1:0]   pad_oe,
  output logic      [NUM_PADS-1:0]   pad_pull_up,
  output logic      [NUM_PADS-1:0]   pad_pull_dn,
  output logic      [NUM_PADS-1:0]   pad_vtol_1v8,
  output logic      [2*NUM_PADS-1:0] pad_mode,
  output logic      [NUM_PADS-1:0]   pad_rx,
  input  wire logic [NUM_PADS-1:0]   native_out,
  input  wire logic [NUM_PADS-1:0]   native_oe,
  output logic      [1:0]            serial_sclk,
  output logic      [1:0]            serial_cs_n,
  output logic      [1:0]            serial_mosi_out,
  output logic      [1:0]            serial_mosi_oe,
  input  wire logic [1:0]            serial_mosi_in,
  input  wire logic [1:0]            serial_miso,
  output logic      [1:0]            strap_value
);
  localparam int NP = gpsi_pkg::NUM_PORTS;

  logic                  p1_q, p2_q, p3_q, plt_active_q;
  logic [NUM_PADS-1:0]   engine_own_q;
  logic [31:0]           dw0 [NUM_PADS];
  logic [31:0]           dw1 [NUM_PADS];
  logic [1:0]            region;
  logic [4:0]            pad_idx;
  logic                  pad_hit;
  logic                  port_idx;
  logic [1:0]            spi_ofs;
  logic [NP-1:0]         spi_start;
  logic [NP-1:0]         spi_busy;
  logic [gpsi_pkg::SPI_DIV_W-1:0] spi_div_q [NP];
  logic [SPI_DATA_W-1:0] spi_tx_q [NP];
  logic [SPI_DATA_W-1:0] spi_rx [NP];
  logic [NP-1:0]         st1_q, st2_q, st3_q;
  logic [1:0]            strap_cnt_q;
  logic                  strap_done_q;
  logic [31:0]           rdata_d;

  assign region   = reg_addr[9:8];
  assign pad_idx  = reg_addr[gpsi_pkg::PAD_IDX_LSB +: gpsi_pkg::PAD_IDX_W];
  assign pad_hit  = region == gpsi_pkg::REGION_PAD && 32'(pad_idx) < NUM_PADS;
  assign port_idx = reg_addr[gpsi_pkg::SPI_PORT_BIT];
  assign spi_ofs  = reg_addr[3:2];

  // Platform reset pin: three flops, a change counts when the last two agree.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      p1_q         <= 1'b0;
      p2_q         <= 1'b0;
      p3_q         <= 1'b0;
      plt_active_q <= 1'b1;
    end else begin
      p1_q <= platform_reset_n;
      p2_q <= p1_q;
      p3_q <= p2_q;
      if (p2_q == p3_q)
        plt_active_q <= ~p3_q;
    end
  end

  // Ownership is set only by the management engine side; the host sees it read-only.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      engine_own_q <= '0;
    else if (engine_own_wr)
      engine_own_q <= engine_own_data;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PADS; g++) begin : g_pad
      gpsi_pad_cell #(
        .IS_NATIVE (NATIVE_DEF[g]),
        .VTOL_OK   (VTOL_CAPABLE[g])
      ) u_pad (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .plt_active (plt_active_q),
        .engine_owned (engine_own_q[g]),
        .wr_en      (reg_wr && pad_hit && 32'(pad_idx) == g),
        .wr_word    (reg_addr[gpsi_pkg::PAD_WORD_BIT]),
        .wr_data    (reg_wdata),
        .pad_in     (pad_in[g]),
        .native_out (native_out[g]),
        .native_oe  (native_oe[g]),
        .pad_out    (pad_out[g]),
        .pad_oe     (pad_oe[g]),
        .pull_up    (pad_pull_up[g]),
        .pull_dn    (pad_pull_dn[g]),
        .vtol_1v8   (pad_vtol_1v8[g]),
        .mode       (pad_mode[2*g +: 2]),
        .rx_level   (pad_rx[g]),
        .dw0        (dw0[g]),
        .dw1        (dw1[g])
      );
    end

    for (g = 0; g < NP; g++) begin : g_port
      assign spi_start[g] = reg_wr && region == gpsi_pkg::REGION_SPI && port_idx == g &&
                            spi_ofs == gpsi_pkg::SPI_CTRL_OFS &&
                            reg_wdata[gpsi_pkg::SPI_GO_BIT] && strap_done_q;

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          spi_div_q[g] <= gpsi_pkg::SPI_DIV_DEF;
          spi_tx_q[g]  <= '0;
        end else if (reg_wr && region == gpsi_pkg::REGION_SPI && port_idx == g &&
                     !spi_busy[g]) begin
          if (spi_ofs == gpsi_pkg::SPI_CTRL_OFS)
            spi_div_q[g] <= reg_wdata[gpsi_pkg::SPI_DIV_LSB +: gpsi_pkg::SPI_DIV_W];
          else if (spi_ofs == gpsi_pkg::SPI_DATA_OFS)
            spi_tx_q[g] <= reg_wdata[SPI_DATA_W-1:0];
        end
      end

      gpsi_serial_port #(
        .DATA_W (SPI_DATA_W),
        .DIV_W  (gpsi_pkg::SPI_DIV_W)
      ) u_port (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .start   (spi_start[g]),
        .tx_data (spi_tx_q[g]),
        .div     (spi_div_q[g]),
        .miso    (serial_miso[g]),
        .busy    (spi_busy[g]),
        .rx_data (spi_rx[g]),
        .sclk    (serial_sclk[g]),
        .cs_n    (serial_cs_n[g]),
        .mosi    (serial_mosi_out[g])
      );

      // Data-out stays undriven until its strap level has been taken.
      assign serial_mosi_oe[g] = strap_done_q;

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          st1_q[g] <= 1'b0;
          st2_q[g] <= 1'b0;
          st3_q[g] <= 1'b0;
        end else begin
          st1_q[g] <= serial_mosi_in[g];
          st2_q[g] <= st1_q[g];
          st3_q[g] <= st2_q[g];
        end
      end
    end
  endgenerate

  // Strap capture happens once after reset release, apart from serial traffic.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      strap_value  <= 2'h0;
    end else if (!strap_done_q) begin
      if (strap_cnt_q != gpsi_pkg::STRAP_WAIT)
        strap_cnt_q <= strap_cnt_q + 2'h1;
      else if (st2_q == st3_q) begin
        strap_value  <= st3_q;
        strap_done_q <= 1'b1;
      end
    end
  end

  // Register read mux; pads owned by the engine read as zero to the host.
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (region)
      gpsi_pkg::REGION_PAD: begin
        if (pad_hit && !engine_own_q[pad_idx[$clog2(NUM_PADS)-1:0]])
          rdata_d = reg_addr[gpsi_pkg::PAD_WORD_BIT] ? dw1[pad_idx[$clog2(NUM_PADS)-1:0]]
                                                     : dw0[pad_idx[$clog2(NUM_PADS)-1:0]];
      end
      gpsi_pkg::REGION_SPI: begin
        case (spi_ofs)
          gpsi_pkg::SPI_CTRL_OFS:
            rdata_d[gpsi_pkg::SPI_DIV_LSB +: gpsi_pkg::SPI_DIV_W] = spi_div_q[port_idx];
          gpsi_pkg::SPI_DATA_OFS: rdata_d[SPI_DATA_W-1:0] = spi_rx[port_idx];
          gpsi_pkg::SPI_STAT_OFS: rdata_d[gpsi_pkg::SPI_BUSY_BIT] = spi_busy[port_idx];
          default:                rdata_d = 32'h0000_0000;
        endcase
      end
      gpsi_pkg::REGION_MISC: begin
        if (reg_addr == gpsi_pkg::OWN_ADDR)
          rdata_d[NUM_PADS-1:0] = engine_own_q;
        else if (reg_addr == gpsi_pkg::STRAP_ADDR)
          rdata_d[1:0] = strap_value;
        else if (reg_addr == gpsi_pkg::PLT_ADDR)
          rdata_d[0] = plt_active_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 32'h0000_0000;
  end
endmodule // gpsi_top
`default_nettype wire

// ==== gpsi_top_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module gpsi_top_asserts #(
  parameter int          NUM_PADS     = 8,
  parameter logic [31:0] NATIVE_DEF   = 32'h0000_0080,
  parameter logic [31:0] VTOL_CAPABLE = 32'h0000_0003
) (
  input wire logic                clk_sys,
  input wire logic                sys_rst,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  input wire logic                platform_reset_n,
  input wire logic [NUM_PADS-1:0] pad_oe,
  input wire logic [NUM_PADS-1:0] pad_rx,
  input wire logic [NUM_PADS-1:0] pad_pull_up,
  input wire logic [NUM_PADS-1:0] pad_pull_dn,
  input wire logic [NUM_PADS-1:0] pad_vtol_1v8,
  input wire logic [1:0]          serial_sclk,
  input wire logic [1:0]          serial_cs_n,
  input wire logic [1:0]          serial_mosi_out,
  input wire logic [1:0]          serial_mosi_oe,
  input wire logic [1:0]          strap_value
);
  // Until software writes anything, every GPIO-default pad must keep its output and its input off.
  logic wrote_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wrote_q <= 1'b0;
    end else if (reg_wr) begin
      wrote_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_pull_exclusive: assert property ((pad_pull_up & pad_pull_dn) == '0)
    else $error("pull up and down together");
  a_vtol_capable: assert property ((pad_vtol_1v8 & ~VTOL_CAPABLE[NUM_PADS-1:0]) == '0)
    else $error("tolerance on incapable pad");
  a_sclk_in_frame: assert property ((serial_sclk & serial_cs_n) == 2'h0)
    else $error("clock outside frame");
  a_cs_after_strap: assert property ((~serial_cs_n & ~serial_mosi_oe) == 2'h0)
    else $error("frame before strap capture");
  a_mosi_hold_high: assert property (serial_sclk[0] && $past(serial_sclk[0])
    |-> $stable(serial_mosi_out[0]))
    else $error("data out moved in clock high");
  a_cs_fall_low: assert property ($fell(serial_cs_n[0]) |-> !serial_sclk[0])
    else $error("clock high at frame start");
  a_strap_stable: assert property (serial_mosi_oe[0] && $past(serial_mosi_oe[0])
    |-> $stable(strap_value))
    else $error("strap moved after capture");
  a_quiet_tx_off: assert property (!wrote_q |-> (pad_oe & ~NATIVE_DEF[NUM_PADS-1:0]) == '0)
    else $error("pad driving at default");
  a_quiet_rx_off: assert property (!wrote_q |-> (pad_rx & ~NATIVE_DEF[NUM_PADS-1:0]) == '0)
    else $error("pad input open at default");
  c_frame: cover property ($fell(serial_cs_n[0]));
  c_plt_held: cover property (!platform_reset_n [*4]);
  c_read_data: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule // gpsi_top_asserts
`default_nettype wire

// ==== gpsi_board_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module gpsi_board_model #(
  parameter bit         STRAP = 1'b0,
  parameter logic [7:0] RESP  = 8'h3c
) (
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi_out,
  input  wire logic        mosi_oe,
  output logic             mosi_in,
  output logic             miso,
  output logic [7:0]       rx_byte
);
  logic [7:0] sh;
  // The strap resistor sets the data-out line while the port is not driving it.
  assign mosi_in = mosi_oe ? mosi_out : STRAP;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    sh = RESP;
  end
  always @(negedge cs_n) begin
    sh = RESP;
    miso = RESP[7];
  end
  always @(posedge sclk) if (!cs_n) rx_byte = {rx_byte[6:0], mosi_out};
  always @(negedge sclk) if (!cs_n) begin
    sh = {sh[6:0], 1'b0};
    miso = sh[7];
  end
  // Between frames the line carries no valid level, so it is shown inverted.
  always @(posedge cs_n) miso = ~miso;
endmodule // gpsi_board_model
`default_nettype wire

// ==== gpsi_top_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module gpsi_top_test;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, platform_reset_n = 1'b1;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, engine_own_wr = 1'b0;
  logic [9:0]  reg_addr = 10'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
  logic [7:0]  engine_own_data = 8'h00, native_out = 8'h01, native_oe = 8'h01;
  logic [7:0]  board_lvl = 8'h5a, pad_pin, pad_out, pad_oe, pull_up, pull_dn, vtol, pad_rx;
  logic [15:0] pad_mode;
  logic [1:0]  sclk, cs_n, mosi_out, mosi_oe, mosi_in, miso, strap;
  logic [7:0]  mrx [2];
  logic [7:0]  tx [2] = '{8'ha5, 8'h5a};
  logic [7:0]  resp [2] = '{8'h3c, 8'hc3};
  logic [9:0]  base;
  int          failures = 0, n_checks = 0, p, k;
  always #25 clk_sys = ~clk_sys;
  assign pad_pin = (pad_oe & pad_out) | (~pad_oe & board_lvl);
  gpsi_top dut (.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clk_sys(clk_sys), .sys_rst(sys_rst),
    .platform_reset_n(platform_reset_n), .engine_own_wr(engine_own_wr),
    .engine_own_data(engine_own_data),
    .pad_in(pad_pin), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pull_up),
    .pad_pull_dn(pull_dn), .pad_vtol_1v8(vtol), .pad_mode(pad_mode), .pad_rx(pad_rx),
    .native_out(native_out), .native_oe(native_oe), .serial_sclk(sclk), .serial_cs_n(cs_n),
    .serial_mosi_out(mosi_out), .serial_mosi_oe(mosi_oe), .serial_mosi_in(mosi_in),
    .serial_miso(miso), .strap_value(strap));
  gpsi_board_model #(.STRAP(1'b1), .RESP(8'h3c)) u_dev0 (.sclk(sclk[0]), .cs_n(cs_n[0]),
    .mosi_out(mosi_out[0]), .mosi_oe(mosi_oe[0]), .mosi_in(mosi_in[0]), .miso(miso[0]),
    .rx_byte(mrx[0]));
  gpsi_board_model #(.STRAP(1'b0), .RESP(8'hc3)) u_dev1 (.sclk(sclk[1]), .cs_n(cs_n[1]),
    .mosi_out(mosi_out[1]), .mosi_oe(mosi_oe[1]), .mosi_in(mosi_in[1]), .miso(miso[1]),
    .rx_byte(mrx[1]));
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic reg_write(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Bit 1 of a first word follows the pin, so callers mask it where the pin is not set up.
  task automatic rd_chk(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    reg_read(a, v);
    `CHK(v & m, e)
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    wait_cyc(20000);
    failures++;
    complete_run();
  end
  initial begin
    wait_cyc(2);
    sys_rst <= 1'b0;
    wait_cyc(10);
    rd_chk(10'h000, 32'hffff_fffd, 32'h0000_0300);
    rd_chk(10'h004, 32'hffff_ffff, 32'h0);
    rd_chk(10'h038, 32'hffff_fffd, 32'h0000_0400);
    `CHK(pad_rx & 8'h7f, 8'h00)
    reg_write(10'h000, 32'h8000_0401);
    reg_write(10'h004, 32'h0200_2000);
    reg_write(10'h008, 32'h0000_0201);
    reg_write(10'h014, 32'h0200_2000);
    reg_write(10'h018, 32'h0000_0100);
    reg_write(10'h038, 32'h8000_0400);
    wait_cyc(6);
    rd_chk(10'h000, 32'hffff_fffd, 32'h8000_0401);
    rd_chk(10'h004, 32'hffff_ffff, 32'h0200_2000);
    rd_chk(10'h014, 32'hffff_ffff, 32'h0000_2000);
    rd_chk(10'h038, 32'hffff_fffd, 32'h0000_0400);
    rd_chk(10'h018, 32'h0000_0002, 32'h0000_0002);
    `CHK(pad_mode[1:0], 2'h1)
    `CHK({pad_oe[1:0], pad_out[1:0]}, 4'hf)
    `CHK({pull_up[2], pull_dn[0], pull_up[0], vtol[2:0]}, 6'h29)
    `CHK(pad_rx[3], 1'b1)
    reg_write(10'h014, 32'h0000_0000);
    reg_write(10'h018, 32'h0000_0300);
    @(posedge clk_sys);
    platform_reset_n <= 1'b0;
    wait_cyc(8);
    reg_write(10'h000, 32'h8000_0401);
    wait_cyc(2);
    rd_chk(10'h000, 32'hffff_fffd, 32'h0000_0300);
    rd_chk(10'h004, 32'hffff_ffff, 32'h0);
    rd_chk(10'h008, 32'hffff_fffd, 32'h0000_0201);
    rd_chk(gpsi_pkg::PLT_ADDR, 32'h1, 32'h1);
    `CHK({pad_mode[1:0], pad_oe[1:0], pad_rx[0], pull_up[0], vtol[0]}, 7'h10)
    `CHK({pull_up[2], pad_rx[3]}, 2'h0)
    @(posedge clk_sys);
    platform_reset_n <= 1'b1;
    wait_cyc(8);
    rd_chk(gpsi_pkg::PLT_ADDR, 32'h1, 32'h0);
    reg_write(10'h004, 32'h0000_0400);
    @(posedge clk_sys);
    engine_own_wr <= 1'b1;
    engine_own_data <= 8'h04;
    @(posedge clk_sys);
    engine_own_wr <= 1'b0;
    reg_write(10'h010, 32'h0000_0001);
    wait_cyc(3);
    rd_chk(10'h010, 32'hffff_ffff, 32'h0);
    rd_chk(gpsi_pkg::OWN_ADDR, 32'hff, 32'h04);
    `CHK(pad_oe[2], 1'b0)
    `CHK({pull_dn[0], pull_up[0]}, 2'h2)
    rd_chk(10'h3f0, 32'hffff_ffff, 32'h0);
    rd_chk(gpsi_pkg::STRAP_ADDR, 32'h3, 32'h1);
    `CHK({strap, mosi_oe}, 4'h7)
    for (p = 0; p < 2; p++) begin
      base = 10'h100 + 10'(p * 16);
      reg_write(base + 10'h4, {24'h0, tx[p]});
      reg_write(base, 32'h0000_0401);
      wait_cyc(1);
      #1;
      `CHK(cs_n[p], 1'b0)
      // A data write in mid-transfer must be ignored.
      reg_write(base + 10'h4, 32'h0000_00ff);
      for (k = 0; k < 100; k++) begin
        reg_read(base + 10'h8, rd);
        if (rd[0] === 1'b0) break;
      end
      `CHK(k < 100, 1'b1)
      `CHK(cs_n[p], 1'b1)
      `CHK(mrx[p], tx[p])
      rd_chk(base + 10'h4, 32'hff, {24'h0, resp[p]});
    end
    complete_run();
  end
endmodule // gpsi_top_test
bind gpsi_top gpsi_top_asserts #(.NUM_PADS(NUM_PADS), .NATIVE_DEF(NATIVE_DEF),
  .VTOL_CAPABLE(VTOL_CAPABLE)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .platform_reset_n(platform_reset_n),
  .pad_oe(pad_oe), .pad_rx(pad_rx), .pad_pull_up(pad_pull_up), .pad_pull_dn(pad_pull_dn),
  .pad_vtol_1v8(pad_vtol_1v8), .serial_sclk(serial_sclk), .serial_cs_n(serial_cs_n),
  .serial_mosi_out(serial_mosi_out), .serial_mosi_oe(serial_mosi_oe),
  .strap_value(strap_value));
`default_nettype wire
